// file: rtl/piomux_pkg.sv
package piomux_pkg;
   localparam int NPORT     = 11;
   localparam int NPIN      = 88;
   localparam int ADDR_W    = 12;
   localparam int MUX_PORT0 = 6;
   localparam int MUX_PORTS = 4;
   localparam int MUX_LSB   = 48;
   localparam int MUX_PINS  = 32;
   localparam int BUS_PINS  = 48;
   localparam int BUS_PORTS = 6;
   localparam int OD_PORT   = 1;
   localparam int KEY_PORT  = 10;
   localparam int KEY_LSB   = 4;
   localparam int PU_W      = 22;

   localparam logic [11:0] DIR_BASE  = 12'h000;
   localparam logic [11:0] LAT_BASE  = 12'h040;
   localparam logic [11:0] FSA_BASE  = 12'h080;
   localparam logic [11:0] FSB_BASE  = 12'h090;
   localparam logic [11:0] FSC_OFS   = 12'h0A0;
   localparam logic [11:0] PU_OFS    = 12'h0A4;
   localparam logic [11:0] PCTL_OFS  = 12'h0A8;
   localparam logic [11:0] MODE_OFS  = 12'h0AC;

   localparam int FSC_P72_BIT     = 0;
   localparam int FSC_KEY_INH_BIT = 7;
   localparam int PCTL_P1_OD_BIT  = 0;
   localparam int MODE_BUS_BIT    = 0;
   localparam int MODE_BUS8_BIT   = 1;

   localparam logic [7:0]      FSC_RW_MASK  = 8'h81;
   localparam logic [7:0]      PCTL_RW_MASK = 8'h01;
   localparam logic [7:0]      MODE_RW_MASK = 8'h03;
   localparam logic [7:0]      RST_BYTE     = 8'h00;
   localparam logic [PU_W-1:0] RST_PU       = 22'h000000;

   // pin index = port * 8 + bit; masks cover ports 0 to 10
   localparam logic [87:0] F1_MASK = {8'h00, 32'hFF037FBB, 48'h0};
   localparam logic [87:0] F2_MASK = {8'h00, 32'h82011D10, 48'h0};
   localparam logic [87:0] F3_MASK = {8'h00, 32'h00000400, 48'h0};
   localparam logic [87:0] OD_MASK = {8'h00, 32'h00000300, 48'h0};
   localparam logic [87:0] IN_MASK = {8'h00, 32'h00200000, 48'h0};
   localparam logic [87:0] NOPU_MASK = OD_MASK | IN_MASK;
   localparam logic [87:0] KEY_MASK  = {8'hF0, 32'h0, 48'h0};

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// file: rtl/piomux_reg.sv
`timescale 1ns/1ps
module piomux_reg #(
   parameter int             W   = 8,
   parameter logic [W-1:0]   RST = '0
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         we,
   input  wire logic [W-1:0] wmask,
   input  wire logic [W-1:0] wdata,
   output logic [W-1:0]      q
);
   logic [W-1:0] q_d;
   logic [W-1:0] q_q;

   always_comb
   begin
      q_d = q_q;
      if (we)
      begin
         q_d = (q_q & ~wmask) | (wdata & wmask);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q_q <= RST;
      end
      else
      begin
         q_q <= q_d;
      end
   end

   assign q = q_q;
endmodule

// file: rtl/piomux_pin.sv
`timescale 1ns/1ps
module piomux_pin #(
   parameter bit HAS_F1   = 1'b0,
   parameter bit HAS_F2   = 1'b0,
   parameter bit HAS_F3   = 1'b0,
   parameter bit OD_FIXED = 1'b0,
   parameter bit NO_PU    = 1'b0,
   parameter bit IN_ONLY  = 1'b0
) (
   input  wire logic dir,
   input  wire logic latch,
   input  wire logic fsa,
   input  wire logic fsb,
   input  wire logic fsc,
   input  wire logic od_sel,
   input  wire logic pu_grp,
   input  wire logic bus_own,
   input  wire logic bus_val,
   input  wire logic bus_en,
   input  wire logic periph1,
   input  wire logic periph2,
   input  wire logic periph3,
   output logic      pad_val,
   output logic      pad_en,
   output logic      pad_pu
);
   logic sel;
   logic drive;
   logic val;
   logic od;

   always_comb
   begin
      sel = latch;
      if (HAS_F1 && fsa)
      begin
         sel = periph1;
         if (HAS_F2 && fsb)
         begin
            sel = periph2;
         end
         else if (HAS_F3 && fsc)
         begin
            sel = periph3;
         end
      end
      drive = IN_ONLY ? 1'b0 : (bus_own ? bus_en : dir);
      val   = bus_own ? bus_val : sel;
      od    = OD_FIXED | (od_sel & ~bus_own);
      // open drain: p-side never on, pin driven only when low
      pad_en  = drive & (~od | ~val);
      pad_val = od ? 1'b0 : val;
      pad_pu  = ~NO_PU & pu_grp & ~dir & ~bus_own;
   end
endmodule

// file: rtl/piomux_top.sv
// Behaviour
// - one direction bit per pin selects input or output
// - bus-owned pins keep direction bits unchanged in bus modes
// - the input-only pin has no direction bit
// - port bit writes the output latch and reads the pin
// - bus-owned pins keep port latch bits unchanged in bus modes
// - first-level select picks port latch or peripheral output
// - second level picks peripheral two, else first or third level
// - second level acts only when first level picks peripheral
// - third level picks first or third output when enabled
// - inhibit bit blocks key-input interrupt on low key pins
// - inhibit bit hides external level of key pins on read
// - one pull-up enable per four pins, only on input pins
// - port one may be open drain with p-side held off
// - port one open drain also applies when usable in bus mode
// - port seven serial pins drive as open drain only
// - selectors route the listed peripheral outputs per pin
// - port seven open-drain pins never get a pull-up
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module piomux_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [87:0] pad_in,
   output logic [87:0]      pad_out,
   output logic [87:0]      pad_oe,
   output logic [87:0]      pad_pullup,
   input  wire logic [47:0] bus_drive,
   input  wire logic [47:0] bus_drive_en,
   input  wire logic [31:0] periph_first,
   input  wire logic [31:0] periph_second,
   input  wire logic [31:0] periph_third,
   output logic             key_irq_req
);
   localparam int NP = piomux_pkg::NPORT;
   localparam int NM = piomux_pkg::MUX_PORTS;

   // write channel state
   logic [11:0] awaddr_d;
   logic [11:0] awaddr_q;
   logic        aw_full_d;
   logic        aw_full_q;
   logic [31:0] wdata_d;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_d;
   logic [3:0]  wstrb_q;
   logic        w_full_d;
   logic        w_full_q;
   logic        bvalid_d;
   logic        bvalid_q;
   logic [1:0]  bresp_d;
   logic [1:0]  bresp_q;
   logic        wr_fire;
   logic        wr_hit;

   // read channel state
   logic        rvalid_d;
   logic        rvalid_q;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_d;
   logic [1:0]  rresp_q;
   logic        rd_hit;
   logic [31:0] rd_val;

   // register file
   logic [7:0]  dir_v [NP];
   logic [7:0]  lat_v [NP];
   logic [7:0]  fsa_v [NM];
   logic [7:0]  fsb_v [NM];
   logic [7:0]  fsc_v;
   logic [7:0]  pctl_v;
   logic [7:0]  mode_v;
   logic [piomux_pkg::PU_W-1:0] pu_v;
   logic [NP-1:0] dir_we;
   logic [NP-1:0] lat_we;
   logic [NM-1:0] fsa_we;
   logic [NM-1:0] fsb_we;
   logic          fsc_we;
   logic          pu_we;
   logic          pctl_we;
   logic          mode_we;
   logic [NP-1:0] own;
   logic [7:0]    dir_wm [NP];
   logic [7:0]    lat_wm [NP];
   logic [31:0]   bmask;

   // pin side
   logic [87:0] dir_flat;
   logic [87:0] lat_flat;
   logic [31:0] fsa_flat;
   logic [31:0] fsb_flat;
   logic [87:0] pin_d;
   logic [87:0] pin_q;
   logic [87:0] pin_rd;
   logic [87:0] cell_val;
   logic [87:0] cell_en;
   logic [87:0] cell_pu;
   logic [87:0] pout_q;
   logic [87:0] poe_q;
   logic [87:0] ppu_q;
   logic        key_d;
   logic        key_q;
   logic        key_inh;

   assign key_inh = fsc_v[piomux_pkg::FSC_KEY_INH_BIT];
   assign bmask   = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                     {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

   // axi write: address and data are taken independently and held
   assign s_axi_awready = ~aw_full_q;
   assign s_axi_wready  = ~w_full_q;
   assign wr_fire       = aw_full_q & w_full_q & ~bvalid_q;

   always_comb
   begin
      awaddr_d  = awaddr_q;
      aw_full_d = aw_full_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      w_full_d  = w_full_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      if (s_axi_awvalid && !aw_full_q)
      begin
         awaddr_d  = s_axi_awaddr;
         aw_full_d = 1'b1;
      end
      if (s_axi_wvalid && !w_full_q)
      begin
         wdata_d  = s_axi_wdata;
         wstrb_d  = s_axi_wstrb;
         w_full_d = 1'b1;
      end
      if (wr_fire)
      begin
         aw_full_d = 1'b0;
         w_full_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = wr_hit ? piomux_pkg::RESP_OKAY
                            : piomux_pkg::RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
      begin
         bvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awaddr_q  <= 12'h000;
         aw_full_q <= 1'b0;
         wdata_q   <= 32'h00000000;
         wstrb_q   <= 4'h0;
         w_full_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= 2'b00;
      end
      else
      begin
         awaddr_q  <= awaddr_d;
         aw_full_q <= aw_full_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         w_full_q  <= w_full_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   // write decode; bus-owned bits are masked off so bus traffic and
   // software writes during bus modes leave them as stored
   always_comb
   begin
      wr_hit = 1'b0;
      fsc_we = 1'b0;
      pu_we  = 1'b0;
      pctl_we = 1'b0;
      mode_we = 1'b0;
      for (int p = 0; p < NP; p++)
      begin
         own[p] = mode_v[piomux_pkg::MODE_BUS_BIT] &
                  (p < piomux_pkg::BUS_PORTS) &
                  ~((p == piomux_pkg::OD_PORT) &
                    mode_v[piomux_pkg::MODE_BUS8_BIT]);
         dir_wm[p] = own[p] ? 8'h00 :
                     ~piomux_pkg::IN_MASK[p*8 +: 8];
         lat_wm[p] = own[p] ? 8'h00 : 8'hFF;
         dir_we[p] = wr_fire &
                     (awaddr_q == 12'(piomux_pkg::DIR_BASE + 4*p));
         lat_we[p] = wr_fire &
                     (awaddr_q == 12'(piomux_pkg::LAT_BASE + 4*p));
         wr_hit = wr_hit | dir_we[p] | lat_we[p];
      end
      for (int k = 0; k < NM; k++)
      begin
         fsa_we[k] = wr_fire &
                     (awaddr_q == 12'(piomux_pkg::FSA_BASE + 4*k));
         fsb_we[k] = wr_fire &
                     (awaddr_q == 12'(piomux_pkg::FSB_BASE + 4*k));
         wr_hit = wr_hit | fsa_we[k] | fsb_we[k];
      end
      if (wr_fire)
      begin
         case (awaddr_q)
            piomux_pkg::FSC_OFS:  fsc_we  = 1'b1;
            piomux_pkg::PU_OFS:   pu_we   = 1'b1;
            piomux_pkg::PCTL_OFS: pctl_we = 1'b1;
            piomux_pkg::MODE_OFS: mode_we = 1'b1;
            default:              fsc_we  = 1'b0;
         endcase
      end
      wr_hit = wr_hit | fsc_we | pu_we | pctl_we | mode_we;
   end

   // every register clears at reset: all pins start as port inputs
   for (genvar p = 0; p < NP; p++)
   begin : g_port
      piomux_reg #(.W(8), .RST(piomux_pkg::RST_BYTE)) u_dir (
         .aclk    (aclk),
         .aresetn (aresetn),
         .we      (dir_we[p]),
         .wmask   (dir_wm[p] & bmask[7:0]),
         .wdata   (wdata_q[7:0]),
         .q       (dir_v[p])
      );
      piomux_reg #(.W(8), .RST(piomux_pkg::RST_BYTE)) u_lat (
         .aclk    (aclk),
         .aresetn (aresetn),
         .we      (lat_we[p]),
         .wmask   (lat_wm[p] & bmask[7:0]),
         .wdata   (wdata_q[7:0]),
         .q       (lat_v[p])
      );
   end

   for (genvar k = 0; k < NM; k++)
   begin : g_fs
      piomux_reg #(.W(8), .RST(piomux_pkg::RST_BYTE)) u_fsa (
         .aclk    (aclk),
         .aresetn (aresetn),
         .we      (fsa_we[k]),
         .wmask   (bmask[7:0]),
         .wdata   (wdata_q[7:0]),
         .q       (fsa_v[k])
      );
      piomux_reg #(.W(8), .RST(piomux_pkg::RST_BYTE)) u_fsb (
         .aclk    (aclk),
         .aresetn (aresetn),
         .we      (fsb_we[k]),
         .wmask   (bmask[7:0]),
         .wdata   (wdata_q[7:0]),
         .q       (fsb_v[k])
      );
   end

   piomux_reg #(.W(8), .RST(piomux_pkg::RST_BYTE)) u_fsc (
      .aclk    (aclk),
      .aresetn (aresetn),
      .we      (fsc_we),
      .wmask   (piomux_pkg::FSC_RW_MASK & bmask[7:0]),
      .wdata   (wdata_q[7:0]),
      .q       (fsc_v)
   );

   piomux_reg #(.W(piomux_pkg::PU_W), .RST(piomux_pkg::RST_PU)) u_pu (
      .aclk    (aclk),
      .aresetn (aresetn),
      .we      (pu_we),
      .wmask   (bmask[piomux_pkg::PU_W-1:0]),
      .wdata   (wdata_q[piomux_pkg::PU_W-1:0]),
      .q       (pu_v)
   );

   piomux_reg #(.W(8), .RST(piomux_pkg::RST_BYTE)) u_pctl (
      .aclk    (aclk),
      .aresetn (aresetn),
      .we      (pctl_we),
      .wmask   (piomux_pkg::PCTL_RW_MASK & bmask[7:0]),
      .wdata   (wdata_q[7:0]),
      .q       (pctl_v)
   );

   piomux_reg #(.W(8), .RST(piomux_pkg::RST_BYTE)) u_mode (
      .aclk    (aclk),
      .aresetn (aresetn),
      .we      (mode_we),
      .wmask   (piomux_pkg::MODE_RW_MASK & bmask[7:0]),
      .wdata   (wdata_q[7:0]),
      .q       (mode_v)
   );

   // read decode works straight off araddr, answer one cycle later
   always_comb
   begin
      rd_hit = 1'b0;
      rd_val = 32'h00000000;
      for (int p = 0; p < NP; p++)
      begin
         if (s_axi_araddr == 12'(piomux_pkg::DIR_BASE + 4*p))
         begin
            rd_hit = 1'b1;
            rd_val = {24'h000000, dir_v[p]};
         end
         if (s_axi_araddr == 12'(piomux_pkg::LAT_BASE + 4*p))
         begin
            rd_hit = 1'b1;
            rd_val = {24'h000000, pin_rd[p*8 +: 8]};
         end
      end
      for (int k = 0; k < NM; k++)
      begin
         if (s_axi_araddr == 12'(piomux_pkg::FSA_BASE + 4*k))
         begin
            rd_hit = 1'b1;
            rd_val = {24'h000000, fsa_v[k]};
         end
         if (s_axi_araddr == 12'(piomux_pkg::FSB_BASE + 4*k))
         begin
            rd_hit = 1'b1;
            rd_val = {24'h000000, fsb_v[k]};
         end
      end
      case (s_axi_araddr)
         piomux_pkg::FSC_OFS:
         begin
            rd_hit = 1'b1;
            rd_val = {24'h000000, fsc_v};
         end
         piomux_pkg::PU_OFS:
         begin
            rd_hit = 1'b1;
            rd_val = {10'h000, pu_v};
         end
         piomux_pkg::PCTL_OFS:
         begin
            rd_hit = 1'b1;
            rd_val = {24'h000000, pctl_v};
         end
         piomux_pkg::MODE_OFS:
         begin
            rd_hit = 1'b1;
            rd_val = {24'h000000, mode_v};
         end
         default:
         begin
            rd_hit = rd_hit;
         end
      endcase
   end

   assign s_axi_arready = ~rvalid_q;

   always_comb
   begin
      rvalid_d = rvalid_q;
      rdata_d  = rdata_q;
      rresp_d  = rresp_q;
      if (s_axi_arvalid && !rvalid_q)
      begin
         rvalid_d = 1'b1;
         rdata_d  = rd_val;
         rresp_d  = rd_hit ? piomux_pkg::RESP_OKAY
                           : piomux_pkg::RESP_SLVERR;
      end
      else if (rvalid_q && s_axi_rready)
      begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h00000000;
         rresp_q  <= 2'b00;
      end
      else
      begin
         rvalid_q <= rvalid_d;
         rdata_q  <= rdata_d;
         rresp_q  <= rresp_d;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;

   // pin side: flatten, sample, and gate key pins while inhibited
   always_comb
   begin
      for (int p = 0; p < NP; p++)
      begin
         dir_flat[p*8 +: 8] = dir_v[p];
         lat_flat[p*8 +: 8] = lat_v[p];
      end
      for (int k = 0; k < NM; k++)
      begin
         fsa_flat[k*8 +: 8] = fsa_v[k];
         fsb_flat[k*8 +: 8] = fsb_v[k];
      end
      pin_d  = pad_in;
      pin_rd = pin_q & ~(piomux_pkg::KEY_MASK & {88{key_inh}} &
                         ~dir_flat);
      key_d  = ~key_inh &
               |(~pin_d[piomux_pkg::KEY_PORT*8+piomux_pkg::KEY_LSB +: 4] &
                 ~dir_flat[piomux_pkg::KEY_PORT*8+piomux_pkg::KEY_LSB +: 4]);
   end

   for (genvar i = 0; i < piomux_pkg::NPIN; i++)
   begin : g_pin
      localparam int M = i - piomux_pkg::MUX_LSB;
      logic fa;
      logic fb;
      logic p1;
      logic p2;
      logic p3;
      logic bv;
      logic be;
      if (M >= 0 && M < piomux_pkg::MUX_PINS)
      begin : g_mux
         assign fa = fsa_flat[M];
         assign fb = fsb_flat[M];
         assign p1 = periph_first[M];
         assign p2 = periph_second[M];
         assign p3 = periph_third[M];
      end
      else
      begin : g_plain
         assign fa = 1'b0;
         assign fb = 1'b0;
         assign p1 = 1'b0;
         assign p2 = 1'b0;
         assign p3 = 1'b0;
      end
      if (i < piomux_pkg::BUS_PINS)
      begin : g_bus
         assign bv = bus_drive[i];
         assign be = bus_drive_en[i];
      end
      else
      begin : g_nobus
         assign bv = 1'b0;
         assign be = 1'b0;
      end
      piomux_pin #(
         .HAS_F1   (piomux_pkg::F1_MASK[i]),
         .HAS_F2   (piomux_pkg::F2_MASK[i]),
         .HAS_F3   (piomux_pkg::F3_MASK[i]),
         .OD_FIXED (piomux_pkg::OD_MASK[i]),
         .NO_PU    (piomux_pkg::NOPU_MASK[i]),
         .IN_ONLY  (piomux_pkg::IN_MASK[i])
      ) u_pin (
         .dir     (dir_flat[i]),
         .latch   (lat_flat[i]),
         .fsa     (fa),
         .fsb     (fb),
         .fsc     (fsc_v[piomux_pkg::FSC_P72_BIT]),
         .od_sel  ((i / 8 == piomux_pkg::OD_PORT) &
                   pctl_v[piomux_pkg::PCTL_P1_OD_BIT]),
         .pu_grp  (pu_v[i / 4]),
         .bus_own (own[i / 8]),
         .bus_val (bv),
         .bus_en  (be),
         .periph1 (p1),
         .periph2 (p2),
         .periph3 (p3),
         .pad_val (cell_val[i]),
         .pad_en  (cell_en[i]),
         .pad_pu  (cell_pu[i])
      );
   end

   // pad drive is registered: one cycle of latency buys glitch-free pins
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_q  <= 88'h0;
         pout_q <= 88'h0;
         poe_q  <= 88'h0;
         ppu_q  <= 88'h0;
         key_q  <= 1'b0;
      end
      else
      begin
         pin_q  <= pin_d;
         pout_q <= cell_val;
         poe_q  <= cell_en;
         ppu_q  <= cell_pu;
         key_q  <= key_d;
      end
   end

   assign pad_out     = pout_q;
   assign pad_oe      = poe_q;
   assign pad_pullup  = ppu_q;
   assign key_irq_req = key_q;
endmodule

// file: testbench/piomux_sva.sv
`timescale 1ns/1ps
module piomux_sva (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [87:0] pad_out,
   input wire logic [87:0] pad_oe,
   input wire logic [87:0] pad_pullup
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   AST_RST_PADS: assert property (disable iff (1'b0)
      !aresetn |=> pad_oe == '0 && pad_pullup == '0)
      else $error("pads live in reset");
   AST_PU_INPUT: assert property (
      (pad_pullup & pad_oe) == '0) else $error("pull-up on output");
   AST_SER_OD: assert property (
      pad_out[57:56] == 2'b00 && pad_pullup[57:56] == 2'b00)
      else $error("serial pins not open drain");
   AST_IN_ONLY: assert property (
      !pad_oe[69] && !pad_pullup[69]) else $error("input pin driven");
   AST_WR_RESP: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("no bvalid");
   AST_B_HOLD: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("bvalid dropped");
   AST_RD_RESP: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no rvalid");
   AST_R_HOLD: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("rdata moved");
   COV_SLVERR: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
   COV_MUX: cover property (pad_oe[58] && pad_out[58]);
   COV_RWAIT: cover property (s_axi_rvalid && !s_axi_rready);
endmodule

// file: testbench/piomux_pins.sv
`timescale 1ns/1ps
module piomux_pins (
   input  wire logic        aclk,
   input  wire logic [87:0] pad_out,
   input  wire logic [87:0] pad_oe,
   input  wire logic [87:0] pad_pullup,
   input  wire logic [87:0] ext_val,
   input  wire logic [87:0] ext_en,
   output logic [87:0]      pad_in
);
   // floating pins toggle so a stale level never reads as a match
   logic flt_q;
   initial flt_q = 1'b0;
   always @(posedge aclk) flt_q <= ~flt_q;
   always_comb
   begin
      for (int i = 0; i < 88; i++)
      begin
         if (pad_oe[i]) pad_in[i] = pad_out[i];
         else if (ext_en[i]) pad_in[i] = ext_val[i];
         else pad_in[i] = pad_pullup[i] | flt_q;
      end
   end
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, key_irq_req;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [31:0] periph_first, periph_second, periph_third;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [87:0] pad_in, pad_out, pad_oe, pad_pullup, ext_val, ext_en;
   logic [47:0] bus_drive, bus_drive_en;
   int          err_total, comparisons;
   piomux_top  u_piomux_top (.*);
   piomux_pins u_piomux_pins (.*);
   task automatic final_report();
      $display("checks %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input bit ok, input string m);
      comparisons++;
      if (!ok)
      begin
         err_total++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // bready is raised late on purpose so the response must stand
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] er = piomux_pkg::RESP_OKAY);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) break;
         if (s_axi_bvalid) s_axi_bready <= 1'b1;
      end
      s_axi_bready <= 1'b0;
      chk(n < 40 && s_axi_bresp === er, "write response");
      if (n == 40) final_report();
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] ex,
                     input logic [1:0] er = piomux_pkg::RESP_OKAY);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) break;
         if (s_axi_rvalid) s_axi_rready <= 1'b1;
      end
      s_axi_rready <= 1'b0;
      chk(n < 40 && s_axi_rresp === er && (er !== piomux_pkg::RESP_OKAY
          || s_axi_rdata === ex), "read data");
      if (n == 40) final_report();
   endtask
   task automatic t_reset();
      rd(12'h018, 32'h0);
      rd(12'h084, 32'h0);
      rd(12'h094, 32'h0);
      wr(12'h08C, 32'h0);
      wr(12'h09C, 32'h0);
      chk(pad_oe === '0 && pad_pullup === '0, "reset pads");
      rd(12'h0FC, 32'h0, piomux_pkg::RESP_SLVERR);
      wr(12'h0FC, 32'hFF, piomux_pkg::RESP_SLVERR);
      $display("test reset done");
   endtask
   task automatic t_dir();
      wr(12'h018, 32'hA5);
      wr(12'h058, 32'h3C);
      wr(12'h020, 32'hFF);
      cyc(2);
      chk(pad_oe[55:48] === 8'hA5, "port6 enables");
      chk((pad_out[55:48] & 8'hA5) === 8'h24, "port6 latch");
      chk(pad_oe[71:64] === 8'hDF, "input-only pin");
      rd(12'h058, 32'h3C & 32'hA5 | 32'hF6 & 32'h5A);
      rd(12'h020, 32'hDF);
      $display("test direction done");
   endtask
   task automatic t_mux();
      logic [6:0] r;
      // fields: first select, second, third, sources 1..3, expected
      logic [6:0] tbl [6] = '{7'h0E, 7'h2E, 7'h49, 7'h53, 7'h75, 7'h5C};
      wr(12'h01C, 32'hFF);
      wr(12'h05C, 32'h00);
      foreach (tbl[i])
      begin
         r = tbl[i];
         wr(12'h084, {29'h0, r[6], 2'h0});
         wr(12'h094, {29'h0, r[5], 2'h0});
         wr(12'h0A0, {31'h0, r[4]});
         periph_first <= {32{r[3]}};
         periph_second <= {32{r[2]}};
         periph_third <= {32{r[1]}};
         cyc(2);
         chk(pad_out[58] === r[0] && pad_oe[58], "mux");
      end
      $display("test mux done");
   endtask
   task automatic t_od();
      wr(12'h0A8, 32'h01);
      wr(12'h004, 32'hFF);
      wr(12'h044, 32'hF0);
      wr(12'h01C, 32'h0F);
      wr(12'h05C, 32'h03);
      wr(12'h0A4, 32'h3FFFFF);
      cyc(2);
      chk(pad_oe[15:8] === 8'h0F && pad_out[15:8] === 8'h00, "od");
      chk(pad_oe[57:56] === 2'b00, "serial od");
      chk(pad_pullup[63:56] === 8'hF0, "pull-ups");
      wr(12'h0A4, 32'h0);
      wr(12'h0AC, 32'h03);
      cyc(2);
      chk(pad_oe[15:8] === 8'h0F, "od in bus mode");
      $display("test open drain done");
   endtask
   task automatic t_bus();
      bus_drive_en <= 48'hFF;
      bus_drive <= 48'h5A;
      wr(12'h0AC, 32'h01);
      wr(12'h000, 32'hFF);
      wr(12'h040, 32'hFF);
      cyc(2);
      chk(pad_oe[7:0] === 8'hFF && pad_out[7:0] === 8'h5A, "bus");
      wr(12'h0AC, 32'h00);
      cyc(2);
      chk(pad_oe[7:0] === 8'h00, "dir kept");
      wr(12'h000, 32'hFF);
      cyc(2);
      chk(pad_out[7:0] === 8'h00, "latch kept");
      $display("test bus done");
   endtask
   task automatic t_key();
      ext_val[87:84] <= 4'h0;
      cyc(4);
      chk(key_irq_req === 1'b1, "key request");
      wr(12'h0A0, 32'h80);
      cyc(2);
      chk(key_irq_req === 1'b0, "key inhibit");
      ext_val[87:84] <= 4'hF;
      cyc(2);
      rd(12'h068, 32'h06);
      $display("test key done");
   endtask
   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   initial
   begin
      {err_total, comparisons} = '0;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {periph_first, periph_second, periph_third} = '0;
      {bus_drive, bus_drive_en} = '0;
      s_axi_wstrb = 4'hF;
      ext_val = {11{8'hF6}};
      ext_en = '1;
      cyc(3);
      aresetn <= 1'b1;
      cyc(1);
      t_reset();
      t_dir();
      t_mux();
      t_od();
      t_bus();
      t_key();
      final_report();
   end
endmodule
bind piomux_top piomux_sva u_piomux_sva (.*);
